/* File: include/tcc_defs.vh */
// register offsets, field positions, reset values and codes of the timer control block
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH
// register byte addresses (one aligned word each)
`define TCC_OFS_CLK      12'h000
`define TCC_OFS_WAVE     12'h004
`define TCC_OFS_CMP      12'h008
`define TCC_OFS_EVT      12'h00C
`define TCC_OFS_BYTE     12'h010
`define TCC_OFS_IRQA     12'h014
`define TCC_OFS_IRQB     12'h018
`define TCC_OFS_STAT     12'h01C
// reset values
`define TCC_RST_REG      8'h00
// writable bit masks (reserved bits read zero)
`define TCC_MSK_CLK      8'h0F
`define TCC_MSK_WAVE     8'hF7
`define TCC_MSK_CMP      8'h0F
`define TCC_MSK_EVT      8'hFF
`define TCC_MSK_BYTE     8'h03
`define TCC_MSK_IRQA     8'h0F
`define TCC_MSK_IRQB     8'hFF
// field positions
`define TCC_CHEN_MSB     7
`define TCC_CHEN_LSB     4
`define TCC_WGM_MSB      2
`define TCC_WGM_LSB      0
`define TCC_EVENT_ACTION_SELECT_MSB    7
`define TCC_EVENT_ACTION_SELECT_LSB    5
`define TCC_EVENT_DELAY_BIT    4
`define TCC_ERRLVL_MSB   3
`define TCC_ERRLVL_LSB   2
`define TCC_WRAPLVL_MSB  1
`define TCC_WRAPLVL_LSB  0
// clock selection codes
`define TCC_CLK_OFF      4'h0
// waveform modes
`define TCC_WGM_NORMAL   3'h0
`define TCC_WGM_FRQ      3'h1
`define TCC_WGM_SS       3'h3
`define TCC_WGM_DUAL_SLOPE_TOP_FLAG    3'h5
`define TCC_WGM_DUAL_SLOPE_BOTH_FLAG   3'h6
`define TCC_WGM_DSBOT    3'h7
// event actions
`define TCC_EVA_NONE     3'h0
`define TCC_EVA_CAPT     3'h1
`define TCC_EVA_UPDOWN   3'h2
`define TCC_EVA_QUADRATURE_DECODE     3'h3
`define TCC_EVA_RESTART  3'h4
`define TCC_EVA_FRQ      3'h5
`define TCC_EVA_PW       3'h6
// byte modes
`define TCC_BYM_NORMAL   2'h0
`define TCC_BYM_BYTE     2'h1
`define TCC_BYM_SPLIT    2'h2
`endif

/* File: hw/tcc_ctrl.v */
// configuration and control logic of a 16-bit timer/counter, apb slave
// How it works
// - clock select zero: no count clock, stopped
// - codes 1..7 divide clock 1..1024
// - top bit set: event channel clocks counter
// - channel enable overrides pin output register; here only while no event action is set
// - capture action: enables gate capture channels
// - normal, frequency, single-slope top/update/flag points
// - dual-slope modes: bottom update, chosen flags
// - normal mode no waveform; enable and direction
// - stopped: compare bits set waveform levels
// - event action field selects event response
// - capture action: compare regs used for capture
// - event delay adds one clock cycle
// - event source: none, channel n, reserved
// - capture channels use n..n+3 modulo eight
// - source ignored unless action non-zero
// - byte mode clears upper counter byte
// - split mode gives two 8-bit counters
// - error and wrap irq levels in control a
// - four channel irq levels in control b
// - wrap flag at top or bottom per mode
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "tcc_defs.vh"
module tcc_ctrl #(
  parameter NCH = 4  // compare/capture channels
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // event channels, asynchronous to pclk
  input  wire [7:0]  event_in,
  // port pin direction per channel (1 = output), from the port block
  input  wire [3:0]  pin_dir_out,
  // counter state points from the counting core
  input  wire        at_top,
  input  wire        at_bottom,
  // count control outputs
  output reg         count_tick,
  output reg         timer_off,
  output reg         upper_byte_clear,
  output reg         split_eight_bit,
  // mode decode to the counting core
  output reg  [1:0]  top_source,
  output reg         update_now,
  output reg         wrap_flag_set,
  output reg         capture_mode,
  output reg  [3:0]  capture_strobe,
  output reg         count_dir_event,
  output reg         restart_event,
  // waveform levels and pin override
  output reg  [3:0]  wave_level,
  output reg  [3:0]  waveform_output_pin_en,
  // interrupt enables (any non-zero level)
  output reg         error_irq_en,
  output reg         wrap_irq_en,
  output reg  [3:0]  channel_irq_en
);

  // control registers
  reg  [7:0]  clock_source_ctrl_q;      // clock select
  reg  [7:0]  waveform_channel_ctrl_q;  // channel enables, mode
  reg  [7:0]  compare_output_ctrl_q;    // direct waveform levels
  reg  [7:0]  event_ctrl_q;             // action, delay, source
  reg  [7:0]  byte_mode_ctrl_q;         // byte mode
  reg  [7:0]  irq_level_ctrl_a_q;       // error and wrap levels
  reg  [7:0]  irq_level_ctrl_b_q;       // channel levels

  // field views
  wire [3:0]  clock_source_select   = clock_source_ctrl_q[3:0];
  wire [3:0]  channel_enable        = waveform_channel_ctrl_q[`TCC_CHEN_MSB:`TCC_CHEN_LSB];
  wire [2:0]  waveform_mode_select  = waveform_channel_ctrl_q[`TCC_WGM_MSB:`TCC_WGM_LSB];
  wire [3:0]  compare_output_level  = compare_output_ctrl_q[3:0];
  wire [2:0]  event_action_select   = event_ctrl_q[`TCC_EVENT_ACTION_SELECT_MSB:`TCC_EVENT_ACTION_SELECT_LSB];
  wire        event_delay           = event_ctrl_q[`TCC_EVENT_DELAY_BIT];
  wire [3:0]  event_source_select   = event_ctrl_q[3:0];
  wire [1:0]  byte_mode_select      = byte_mode_ctrl_q[1:0];
  wire [1:0]  error_irq_level       = irq_level_ctrl_a_q[`TCC_ERRLVL_MSB:`TCC_ERRLVL_LSB];
  wire [1:0]  wrap_irq_level        = irq_level_ctrl_a_q[`TCC_WRAPLVL_MSB:`TCC_WRAPLVL_LSB];

  // apb phase decode
  wire        apb_wr = psel & penable & pwrite;
  wire        apb_rd = psel & penable & ~pwrite;

  // address decode shared by read and write paths
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `TCC_OFS_CLK)  | (a == `TCC_OFS_WAVE) |
                  (a == `TCC_OFS_CMP)  | (a == `TCC_OFS_EVT)  |
                  (a == `TCC_OFS_BYTE) | (a == `TCC_OFS_IRQA) |
                  (a == `TCC_OFS_IRQB) | (a == `TCC_OFS_STAT);
    end
  endfunction

  // capture actions share one decode
  function is_capture;
    input [2:0] act;
    begin
      is_capture = (act == `TCC_EVA_CAPT) | (act == `TCC_EVA_FRQ) | (act == `TCC_EVA_PW);
    end
  endfunction

  // register writes; reserved bits are masked so they always read zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_ctrl_q     <= `TCC_RST_REG;
      waveform_channel_ctrl_q <= `TCC_RST_REG;
      compare_output_ctrl_q   <= `TCC_RST_REG;
      event_ctrl_q            <= `TCC_RST_REG;
      byte_mode_ctrl_q        <= `TCC_RST_REG;
      irq_level_ctrl_a_q      <= `TCC_RST_REG;
      irq_level_ctrl_b_q      <= `TCC_RST_REG;
    end else if (apb_wr) begin
      case (paddr)
        `TCC_OFS_CLK:  clock_source_ctrl_q     <= pwdata[7:0] & `TCC_MSK_CLK;
        `TCC_OFS_WAVE: waveform_channel_ctrl_q <= pwdata[7:0] & `TCC_MSK_WAVE;
        `TCC_OFS_CMP:  compare_output_ctrl_q   <= pwdata[7:0] & `TCC_MSK_CMP;
        `TCC_OFS_EVT:  event_ctrl_q            <= pwdata[7:0] & `TCC_MSK_EVT;
        `TCC_OFS_BYTE: byte_mode_ctrl_q        <= pwdata[7:0] & `TCC_MSK_BYTE;
        `TCC_OFS_IRQA: irq_level_ctrl_a_q      <= pwdata[7:0] & `TCC_MSK_IRQA;
        `TCC_OFS_IRQB: irq_level_ctrl_b_q      <= pwdata[7:0] & `TCC_MSK_IRQB;
        default: begin
          // unmapped or read-only: nothing stored
        end
      endcase
    end
  end

  // read mux; status word shows block state
  reg  [31:0] rd_mux;
  always @* begin
    case (paddr)
      `TCC_OFS_CLK:  rd_mux = {24'h00_0000, clock_source_ctrl_q};
      `TCC_OFS_WAVE: rd_mux = {24'h00_0000, waveform_channel_ctrl_q};
      `TCC_OFS_CMP:  rd_mux = {24'h00_0000, 4'h0, wave_level};  // live levels
      `TCC_OFS_EVT:  rd_mux = {24'h00_0000, event_ctrl_q};
      `TCC_OFS_BYTE: rd_mux = {24'h00_0000, byte_mode_ctrl_q};
      `TCC_OFS_IRQA: rd_mux = {24'h00_0000, irq_level_ctrl_a_q};
      `TCC_OFS_IRQB: rd_mux = {24'h00_0000, irq_level_ctrl_b_q};
      `TCC_OFS_STAT: rd_mux = {24'h00_0000, capture_mode, split_eight_bit,
                               timer_off, 1'b0, waveform_output_pin_en};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // apb answer: pready in the access cycle, zero wait states
  // a master that stretches its access phase sees pready drop again; the slave
  // never needs more than one access cycle, so no wait state is ever inserted
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;   // high during the access phase
      // a write to the status word is accepted without error and dropped
      pslverr <= psel & ~penable & ~is_mapped(paddr);
      if (psel & ~penable & ~pwrite)
        prdata <= rd_mux;
    end
  end

  // two-flop synchroniser on the event channels
  // only the second stage feeds logic, the first may still be settling;
  // a channel level shorter than one clock can be missed
  reg  [7:0]  ev_s1_q;
  reg  [7:0]  ev_s2_q;
  reg  [7:0]  ev_prev_q;     // for edge detection
  reg  [7:0]  ev_dly_q;      // one-cycle delayed edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_s1_q   <= 8'h00;
      ev_s2_q   <= 8'h00;
      ev_prev_q <= 8'h00;
      ev_dly_q  <= 8'h00;
    end else begin
      ev_s1_q   <= event_in;
      ev_s2_q   <= ev_s1_q;
      ev_prev_q <= ev_s2_q;
      ev_dly_q  <= ev_s2_q & ~ev_prev_q;
    end
  end

  // event pulse per channel, optionally delayed one clock to match a cascade carry
  wire [7:0]  ev_edge  = ev_s2_q & ~ev_prev_q;
  wire [7:0]  ev_pulse = event_delay ? ev_dly_q : ev_edge;

  // prescaler: free-running counter, divided ticks from its carries
  // a change between two running codes keeps the count, so the first tick
  // after it may come early; stopping first gives a whole first period
  reg  [9:0]  pre_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pre_q <= 10'h000;
    else if (clock_source_select == `TCC_CLK_OFF)
      pre_q <= 10'h000;   // held while stopped so the first period is whole
    else
      pre_q <= pre_q + 10'h001;
  end

  // tick select: divided peripheral clock or an event channel
  // codes with bit 3 clear above 7 cannot occur, so the default is the event path
  reg         tick_d;
  always @* begin
    case (clock_source_select)
      4'h1:    tick_d = 1'b1;
      4'h2:    tick_d = (pre_q[0]   == 1'b1);
      4'h3:    tick_d = (pre_q[1:0] == 2'h3);
      4'h4:    tick_d = (pre_q[2:0] == 3'h7);
      4'h5:    tick_d = (pre_q[5:0] == 6'h3F);
      4'h6:    tick_d = (pre_q[7:0] == 8'hFF);
      4'h7:    tick_d = (pre_q      == 10'h3FF);
      default: tick_d = clock_source_select[3] &
                        ev_pulse[clock_source_select[2:0]];
    endcase
    if (clock_source_select == `TCC_CLK_OFF)
      tick_d = 1'b0;
  end

  // event routing: capture channels walk from channel n modulo eight
  wire        src_valid = event_source_select[3];
  wire        act_on    = (event_action_select != `TCC_EVA_NONE);
  wire        cap_on    = is_capture(event_action_select);
  wire        ev_sel    = src_valid & act_on & ev_pulse[event_source_select[2:0]];
  // one strobe bit per channel, each bit with its own continuous driver
  wire [3:0]  cap_d;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_cap
      // channel offset kept as a constant; its low three bits wrap modulo eight
      localparam [31:0] CH_OFS = g;
      wire [2:0] chn = event_source_select[2:0] + CH_OFS[2:0];
      // a disabled channel ignores its event even in capture mode
      assign cap_d[g] = src_valid & cap_on & channel_enable[g] & ev_pulse[chn];
    end
  endgenerate

  // mode decode: top source, update point and wrap flag point
  // top and bottom are levels from the core; the tick keeps a slow clock
  // from flagging the same point on every peripheral cycle
  reg  [1:0]  top_d;      // 0 period, 1 channel a compare
  reg         upd_d;
  reg         wrap_d;
  always @* begin
    top_d  = 2'h0;
    upd_d  = 1'b0;
    wrap_d = 1'b0;
    case (waveform_mode_select)
      `TCC_WGM_NORMAL: begin
        upd_d  = at_top;
        wrap_d = at_top;
      end
      `TCC_WGM_FRQ: begin
        top_d  = 2'h1;
        upd_d  = at_top;
        wrap_d = at_top;
      end
      `TCC_WGM_SS: begin
        upd_d  = at_bottom;
        wrap_d = at_bottom;
      end
      `TCC_WGM_DUAL_SLOPE_TOP_FLAG: begin
        upd_d  = at_bottom;
        wrap_d = at_top;
      end
      `TCC_WGM_DUAL_SLOPE_BOTH_FLAG: begin
        upd_d  = at_bottom;
        wrap_d = at_top | at_bottom;
      end
      `TCC_WGM_DSBOT: begin
        upd_d  = at_bottom;
        wrap_d = at_bottom;
      end
      default: begin
        // reserved modes: no update, no flag
      end
    endcase
    // points only count on a counter clock; the wrap point follows the mode
    upd_d  = upd_d & tick_d;
    wrap_d = wrap_d & tick_d;
  end

  // waveform levels: software writes them directly only while stopped
  wire        wave_mode = (waveform_mode_select != `TCC_WGM_NORMAL);
  reg  [3:0]  wave_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wave_q <= 4'h0;
    else if (clock_source_select == `TCC_CLK_OFF)
      wave_q <= compare_output_level;
    else if (wave_mode & tick_d & at_top & (waveform_mode_select == `TCC_WGM_SS))
      wave_q <= 4'h0;   // single-slope clears at top; compare set comes from the core
    else if (wave_mode & tick_d & at_bottom & waveform_mode_select[2])
      wave_q <= 4'hF;   // dual-slope sets at bottom
  end

  // pin override: needs a waveform mode, no event action, enable and output direction
  // the port block still owns the direction, so an input pin never shows the wave
  reg  [3:0]  pin_en_d;
  always @* begin
    pin_en_d = 4'h0;
    if (wave_mode & ~act_on)
      pin_en_d = channel_enable & pin_dir_out;
  end

  // interrupt levels: zero disables, any other level requests
  // the priority itself is left to the interrupt controller behind this block
  wire        err_en_d  = (error_irq_level != 2'h0);
  wire        wrap_en_d = (wrap_irq_level  != 2'h0);
  wire [3:0]  ch_en_d;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_irq
      // channel g owns the level pair at bits 2g+1:2g
      assign ch_en_d[g] = (irq_level_ctrl_b_q[2*g+1 -: 2] != 2'h0);
    end
  endgenerate

  // registered outputs to the counting core and the port
  // one stage on every output keeps decode glitches away from the core,
  // traded for one cycle of latency on every pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_tick             <= 1'b0;
      timer_off              <= 1'b1;
      upper_byte_clear       <= 1'b0;
      split_eight_bit        <= 1'b0;
      top_source             <= 2'h0;
      update_now             <= 1'b0;
      wrap_flag_set          <= 1'b0;
      capture_mode           <= 1'b0;
      capture_strobe         <= 4'h0;
      count_dir_event        <= 1'b0;
      restart_event          <= 1'b0;
      wave_level             <= 4'h0;
      waveform_output_pin_en <= 4'h0;
      error_irq_en           <= 1'b0;
      wrap_irq_en            <= 1'b0;
      channel_irq_en         <= 4'h0;
    end else begin
      count_tick             <= tick_d;
      timer_off              <= (clock_source_select == `TCC_CLK_OFF);
      upper_byte_clear       <= (byte_mode_select == `TCC_BYM_BYTE) & tick_d;
      split_eight_bit        <= (byte_mode_select == `TCC_BYM_SPLIT);
      top_source             <= top_d;
      update_now             <= upd_d & ~cap_on;
      wrap_flag_set          <= wrap_d;
      capture_mode           <= cap_on;
      capture_strobe         <= cap_d;
      // non-capture actions act on the selected channel only
      count_dir_event        <= ev_sel & ((event_action_select == `TCC_EVA_UPDOWN) |
                                          (event_action_select == `TCC_EVA_QUADRATURE_DECODE));
      restart_event          <= ev_sel & (event_action_select == `TCC_EVA_RESTART);
      wave_level             <= wave_q;
      waveform_output_pin_en <= pin_en_d;
      error_irq_en           <= err_en_d;
      wrap_irq_en            <= wrap_en_d;
      channel_irq_en         <= ch_en_d;
    end
  end

endmodule

/* File: testbench/tcc_far.sv */
// far-side model: event channels and port pin directions
`timescale 1ns/1ps
module tcc_far (
  // clock
  input  wire        pclk,
  // requests from the bench
  input  wire  [7:0] fire,
  input  wire  [3:0] dir_set,
  // lines toward the timer
  output logic [7:0] event_in = 8'h00,
  output logic [3:0] pin_dir_out
);
  logic [7:0] hold_q = 8'h00; // second cycle of an event level
  // a fired channel rises after an edge and stays up two cycles,
  // long enough to survive the two-flop synchroniser
  always @(posedge pclk) begin
    hold_q   <= fire;
    event_in <= fire | hold_q;
  end
  // pin directions follow the port setting
  assign pin_dir_out = dir_set;
endmodule

/* File: testbench/tcc_chk.sv */
// concurrent checks on the timer control block ports
`timescale 1ns/1ps
module tcc_chk (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  // observed outputs
  input wire        count_tick,
  input wire        timer_off,
  input wire        split_eight_bit,
  input wire        capture_mode,
  input wire        error_irq_en,
  input wire        wrap_irq_en,
  input wire  [3:0] channel_irq_en
);
  logic [7:0] sh_clk_q, sh_evt_q, sh_byt_q, sh_ira_q, sh_irb_q; // shadow copies
  logic [1:0] quiet_q; // edges since the last write, saturating
  wire        wr      = psel & penable & pwrite & pready;
  wire        mapped  = paddr[1:0] == 2'h0 && paddr <= 12'h01C;
  wire        settled = quiet_q == 2'h3;
  // shadows follow completed writes; outputs lag them by a register stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sh_clk_q, sh_evt_q, sh_byt_q, sh_ira_q, sh_irb_q} <= 40'h00_0000_0000;
      quiet_q <= 2'h3;
    end else begin
      quiet_q <= wr ? 2'h0 : (settled ? quiet_q : quiet_q + 2'h1);
      if (wr && paddr == 12'h000) sh_clk_q <= pwdata[7:0];
      if (wr && paddr == 12'h00C) sh_evt_q <= pwdata[7:0];
      if (wr && paddr == 12'h010) sh_byt_q <= pwdata[7:0];
      if (wr && paddr == 12'h014) sh_ira_q <= pwdata[7:0];
      if (wr && paddr == 12'h018) sh_irb_q <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_access_ready: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_unmapped_err: assert property (pready && !(pwrite && paddr == 12'h01C) |-> pslverr == !mapped)
    else $error("error response wrong for address");
  a_off_stops: assert property (timer_off [*3] |-> !count_tick)
    else $error("tick while stopped");
  a_off_level: assert property (settled |-> timer_off == (sh_clk_q[3:0] == 4'h0))
    else $error("stopped level wrong");
  a_split_level: assert property (settled |-> split_eight_bit == (sh_byt_q[1:0] == 2'h2))
    else $error("split level wrong");
  a_capture_level: assert property (settled |-> capture_mode == (sh_evt_q[7:5] inside {3'h1, 3'h5, 3'h6}))
    else $error("capture level wrong");
  a_error_irq: assert property (settled |-> error_irq_en == |sh_ira_q[3:2])
    else $error("error irq enable wrong");
  a_wrap_irq: assert property (settled |-> wrap_irq_en == |sh_ira_q[1:0])
    else $error("wrap irq enable wrong");
  a_channel_irq: assert property (settled |-> channel_irq_en ==
    {|sh_irb_q[7:6], |sh_irb_q[5:4], |sh_irb_q[3:2], |sh_irb_q[1:0]})
    else $error("channel irq enables wrong");
  c_refused: cover property (pslverr);
  c_capture: cover property (settled && capture_mode);
  c_split: cover property (settled && split_eight_bit);
endmodule
bind tcc_ctrl tcc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .count_tick(count_tick), .timer_off(timer_off), .split_eight_bit(split_eight_bit),
  .capture_mode(capture_mode), .error_irq_en(error_irq_en), .wrap_irq_en(wrap_irq_en),
  .channel_irq_en(channel_irq_en));

/* File: testbench/tcc_tb.sv */
// self-checking bench of the timer control block
`timescale 1ns/1ps
`include "tcc_defs.vh"
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, at_top, at_bottom, pready, pslverr, er;
  logic        tick, off, ubc, spl, upd, wrp, capm, cde, rse, eie, wie;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  tsrc;
  logic [3:0]  cst, wlv, pen, cie, dir_set, pin_dir_out;
  logic [7:0]  event_in, fire;
  logic [6:0]  got;
  int          error_cnt, n_tests, cyc, lat, lat0, n, e;
  // address, written byte, byte read back; reserved bits are written as zero
  logic [27:0] rows [7] = '{{`TCC_OFS_CMP, 16'h0F0F}, {`TCC_OFS_WAVE, 16'hF7F7},
    {`TCC_OFS_EVT, 16'hDFDF}, {`TCC_OFS_BYTE, 16'h0202}, {`TCC_OFS_IRQA, 16'h0F0F},
    {`TCC_OFS_IRQB, 16'hFFFF}, {`TCC_OFS_CLK, 16'h0F0F}};
  int          dv [7] = '{0, 1, 2, 3, 6, 8, 10};     // log2 of each prescale
  logic [3:0]  md [6] = '{0, 1, 3, 5, 6, 7};         // legal waveform modes
  logic [3:0]  fl [6] = '{10, 10, 5, 9, 13, 5};      // wrap top/bot, update top/bot
  tcc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(event_in), .pin_dir_out(pin_dir_out), .at_top(at_top),
    .at_bottom(at_bottom), .count_tick(tick), .timer_off(off), .upper_byte_clear(ubc),
    .split_eight_bit(spl), .top_source(tsrc), .update_now(upd), .wrap_flag_set(wrp),
    .capture_mode(capm), .capture_strobe(cst), .count_dir_event(cde), .restart_event(rse),
    .wave_level(wlv), .waveform_output_pin_en(pen), .error_irq_en(eie),
    .wrap_irq_en(wie), .channel_irq_en(cie));
  tcc_far u_far (.pclk(pclk), .fire(fire), .dir_set(dir_set), .event_in(event_in),
    .pin_dir_out(pin_dir_out));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // hang guard: far above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
    rd = prdata;
    er = pslverr;
    chk(k < 20, 1);
    {psel, penable} <= 2'b00;
  endtask
  // fire one event channel and gather pulses for ten edges
  task automatic fire_watch(input int ch);
    @(posedge pclk);
    fire <= 8'h01 << ch;
    @(posedge pclk);
    fire <= 8'h00;
    got = 0;
    for (int i = 1; i <= 10; i++) begin
      @(posedge pclk);
      // the count tick may run free, so latency looks at event pulses only
      if (got[5:0] == 0) lat = i;
      got |= {tick, rse, cde, cst};
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, at_top, at_bottom, paddr, pwdata, fire} = 0;
    dir_set = 4'b0101;
    presetn = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(rows[i][27:16], 0, 0);
      chk(rd, 0);
      apb(rows[i][27:16], 1, rows[i][15:8]);
      // compare levels read back live and lag a write by two register stages
      repeat (2) @(posedge pclk);
      apb(rows[i][27:16], 0, 0);
      chk(rd, rows[i][7:0]);
    end
    // second reset in mid-run restores every register
    @(posedge pclk);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(rows[i][27:16], 0, 0);
      chk(rd, 0);
    end
    apb(12'h020, 0, 0);
    chk(er, 1);
    chk(rd, 0);
    foreach (dv[c]) begin
      apb(`TCC_OFS_CLK, 1, c + 1);
      repeat (8) @(posedge pclk);
      n = 0;
      repeat (1024) begin
        @(posedge pclk);
        n += tick;
      end
      e = 1024 >> dv[c];
      chk((n + 1 >= e && n <= e + 1) ? e : n, e);
    end
    for (int ch = 2; ch < 4; ch++) begin
      apb(`TCC_OFS_CLK, 1, 32'h0000_000B);
      fire_watch(ch);
      chk(got[6], ch == 3);
    end
    apb(`TCC_OFS_CLK, 1, 1);
    // capture needs the channel enables; the mode stays normal
    apb(`TCC_OFS_WAVE, 1, 32'h0000_00F0);
    foreach (dv[a]) if (a < 4) begin
      apb(`TCC_OFS_EVT, 1, {a == 3 ? 3'h4 : 3'(a), 5'h08});
      fire_watch(0);
      chk(got[5:0], a == 0 ? 0 : (a == 1 ? 1 : (a == 2 ? 16 : 32)));
    end
    for (int k = 0; k < 4; k++) begin
      apb(`TCC_OFS_EVT, 1, 32'h0000_002E);
      fire_watch((6 + k) % 8);
      chk(got[3:0], 4'h1 << k);
      if (k == 0) lat0 = lat;
    end
    apb(`TCC_OFS_EVT, 1, 32'h0000_003E);
    fire_watch(6);
    chk(lat, lat0 + 1);
    apb(`TCC_OFS_EVT, 1, 0);
    foreach (md[m]) begin
      apb(`TCC_OFS_WAVE, 1, md[m]);
      for (int b = 0; b < 2; b++) begin
        @(posedge pclk);
        {at_top, at_bottom} <= b ? 2'b01 : 2'b10;
        @(posedge pclk);
        {at_top, at_bottom} <= 2'b00;
        got = 0;
        repeat (3) begin
          @(posedge pclk);
          got |= {wrp, upd};
        end
        chk(got[1:0], {fl[m][3 - b], fl[m][1 - b]});
      end
      chk(tsrc, md[m] == 1);
    end
    apb(`TCC_OFS_WAVE, 1, 32'h0000_00F3);
    repeat (3) @(posedge pclk);
    chk(pen, 4'b0101);
    apb(`TCC_OFS_WAVE, 1, 32'h0000_00F0);
    repeat (3) @(posedge pclk);
    chk(pen, 0);
    apb(`TCC_OFS_BYTE, 1, 1);
    n = 0;
    repeat (8) begin
      @(posedge pclk);
      n += ubc;
    end
    chk(n > 0, 1);
    apb(`TCC_OFS_BYTE, 1, 2);
    apb(`TCC_OFS_CLK, 1, 0);
    apb(`TCC_OFS_CMP, 1, 5);
    repeat (3) @(posedge pclk);
    chk(wlv, 5);
    report_and_stop();
  end
endmodule
